// ==== pkg/rapc_pkg.sv ====
// constants, types and helpers for the region attribute and permission checker
package rapc_pkg;

  localparam int unsigned NUM_REGIONS = 8;
  localparam int unsigned AXI_ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RNUM = 8'h04;
  localparam logic [7:0] OFS_RATTR = 8'h08;
  localparam logic [7:0] OFS_FSTAT = 8'h0c;
  localparam logic [7:0] OFS_FADDR = 8'h10;
  localparam logic [7:0] OFS_WORD_MASK = 8'hfc;

  // control register fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_BG_BIT = 1;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0003;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] RNUM_WMASK = 32'h0000_0007;
  localparam logic [31:0] RNUM_RESET = 32'h0000_0000;

  // region_attribute_size_reg fields
  localparam int unsigned ATTR_EN_BIT = 0;
  localparam int unsigned ATTR_B_BIT = 16;
  localparam int unsigned ATTR_C_BIT = 17;
  localparam int unsigned ATTR_S_BIT = 18;
  localparam int unsigned ATTR_TEX_LSB = 19;
  localparam int unsigned ATTR_AP_LSB = 24;
  localparam int unsigned ATTR_XN_BIT = 28;
  localparam logic [31:0] ATTR_WMASK = 32'h173f_0001;
  localparam logic [31:0] ATTR_RESET = 32'h0000_0000;

  // memmanage_fault_status fields
  localparam int unsigned FST_IACC_BIT = 0;
  localparam int unsigned FST_DACC_BIT = 1;
  localparam int unsigned FST_ADDRV_BIT = 7;
  localparam logic [31:0] FST_RESET = 32'h0000_0000;
  localparam logic [31:0] FADDR_RESET = 32'h0000_0000;

  // access permission codes
  localparam logic [2:0] AP_NONE = 3'h0;
  localparam logic [2:0] AP_PRIV_RW = 3'h1;
  localparam logic [2:0] AP_USER_RO = 3'h2;
  localparam logic [2:0] AP_FULL = 3'h3;
  localparam logic [2:0] AP_RSVD = 3'h4;
  localparam logic [2:0] AP_PRIV_RO = 3'h5;
  localparam logic [2:0] AP_RO_A = 3'h6;
  localparam logic [2:0] AP_RO_B = 3'h7;

  // two-bit cache policy codes
  localparam logic [1:0] POL_NC = 2'h0;
  localparam logic [1:0] POL_WB_RWA = 2'h1;
  localparam logic [1:0] POL_WT_NWA = 2'h2;
  localparam logic [1:0] POL_WB_NWA = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MT_STRONG = 2'h0,
    MT_DEVICE = 2'h1,
    MT_NORMAL = 2'h2
  } rapc_memtype_t;

  typedef struct packed {
    logic [31:0] addr;
    logic priv;
    logic write;
    logic fetch;
  } rapc_acc_req_t;

  typedef struct packed {
    logic en;
    logic xn;
    logic [2:0] ap;
    logic [2:0] type_extension_field;
    logic s;
    logic c;
    logic b;
  } rapc_attr_t;

  typedef struct packed {
    rapc_memtype_t mtype;
    logic shareable;
    logic [1:0] inner;
    logic [1:0] outer;
    logic reserved;
  } rapc_dec_t;

  // attributes of the default map, used for the background region
  localparam rapc_dec_t BG_DEC = '{MT_NORMAL, 1'b0, POL_WT_NWA, POL_WT_NWA, 1'b0};

  function automatic rapc_attr_t attr_of(input logic [31:0] w);
    rapc_attr_t a;
    a.en = w[ATTR_EN_BIT];
    a.xn = w[ATTR_XN_BIT];
    a.ap = w[ATTR_AP_LSB +: 3];
    a.type_extension_field = w[ATTR_TEX_LSB +: 3];
    a.s = w[ATTR_S_BIT];
    a.c = w[ATTR_C_BIT];
    a.b = w[ATTR_B_BIT];
    return a;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return ((old & ~m) | (wd & m)) & mask;
  endfunction

endpackage

// ==== logic/rapc_attr_dec.sv ====
// decoder from type extension, shareable, cacheable and bufferable bits to memory type and policy
module rapc_attr_dec
  import rapc_pkg::*;
(
  input rapc_pkg::rapc_attr_t attr,
  output rapc_pkg::rapc_dec_t dec
);

  // reserved codes fall back to strongly ordered so the output never wanders
  always_comb
  begin
    dec = '{MT_STRONG, 1'b1, POL_NC, POL_NC, 1'b1};
    unique casez (attr.type_extension_field)
      3'b000:
      begin
        if (!attr.c && !attr.b)
          dec = '{MT_STRONG, 1'b1, POL_NC, POL_NC, 1'b0};
        else if (!attr.c)
          dec = '{MT_DEVICE, 1'b1, POL_NC, POL_NC, 1'b0};
        else
          dec = '{MT_NORMAL, attr.s, POL_WT_NWA, POL_WT_NWA, 1'b0};
      end
      3'b001:
      begin
        if (!attr.c && !attr.b)
          dec = '{MT_NORMAL, attr.s, POL_NC, POL_NC, 1'b0};
        else if (attr.c && attr.b)
          dec = '{MT_NORMAL, attr.s, POL_WB_RWA, POL_WB_RWA, 1'b0};
      end
      3'b010:
      begin
        if (!attr.c && !attr.b)
          dec = '{MT_DEVICE, 1'b0, POL_NC, POL_NC, 1'b0};
      end
      3'b011:
      begin
        dec.reserved = 1'b1;
      end
      3'b1??:
      begin
        // policy codes pass through unchanged
        dec = '{MT_NORMAL, attr.s, {attr.c, attr.b}, attr.type_extension_field[1:0], 1'b0};
      end
    endcase
  end

endmodule

// ==== logic/rapc_perm_chk.sv ====
// access permission and execute-never check for one access against one region
module rapc_perm_chk
  import rapc_pkg::*;
(
  input rapc_pkg::rapc_attr_t attr,
  input logic priv,
  input logic write,
  input logic fetch,
  output logic fault
);

  logic rd_ok;
  logic wr_ok;

  // a fetch counts as a read
  always_comb
  begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    unique case (attr.ap)
      AP_NONE:
      begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
      AP_PRIV_RW:
      begin
        rd_ok = priv;
        wr_ok = priv;
      end
      AP_USER_RO:
      begin
        rd_ok = 1'b1;
        wr_ok = priv;
      end
      AP_FULL:
      begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      AP_RSVD:
      begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
      AP_PRIV_RO:
      begin
        rd_ok = priv;
        wr_ok = 1'b0;
      end
      AP_RO_A, AP_RO_B:
      begin
        rd_ok = 1'b1;
        wr_ok = 1'b0;
      end
    endcase
  end

  assign fault = (write ? !wr_ok : !rd_ok) || (fetch && attr.xn);

endmodule

// ==== logic/rapc_top.sv ====
// region attribute decoder and access permission checker with an AXI4-Lite register port
module rapc_top
  import rapc_pkg::*;
(
  input logic CLK,
  input logic RESETN,
  input logic [rapc_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input logic [31:0] S_AXI_WDATA,
  input logic [3:0] S_AXI_WSTRB,
  input logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input logic S_AXI_BREADY,
  input logic [rapc_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
  input logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input logic S_AXI_RREADY,
  input logic ACC_VALID,
  input rapc_pkg::rapc_acc_req_t ACC_REQ,
  input logic [rapc_pkg::NUM_REGIONS-1:0] ACC_HIT,
  output logic RSP_VALID,
  output logic RSP_FAULT,
  output logic RSP_BG,
  output logic [2:0] RSP_REGION,
  output rapc_pkg::rapc_dec_t RSP_ATTR,
  output logic MMFAULT
);

  import rapc_pkg::*;

  function automatic logic [2:0] top_index(input logic [NUM_REGIONS-1:0] hits);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < NUM_REGIONS; i++)
    begin
      if (hits[i])
        idx = 3'(i);
    end
    return idx;
  endfunction

  function automatic logic ofs_known(input logic [7:0] ofs);
    return (ofs == OFS_CTRL) || (ofs == OFS_RNUM) || (ofs == OFS_RATTR) ||
           (ofs == OFS_FSTAT) || (ofs == OFS_FADDR);
  endfunction

  // bus slave state
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // registers
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] rnum_q;
  logic [31:0] rnum_d;
  logic [31:0] rattr_q [NUM_REGIONS];
  logic [31:0] fstat_q;
  logic [31:0] fstat_d;
  logic [31:0] faddr_q;
  logic [31:0] faddr_d;

  // response state
  logic rsp_valid_q;
  logic rsp_fault_q;
  logic rsp_bg_q;
  logic [2:0] rsp_region_q;
  rapc_dec_t rsp_attr_q;
  logic mmfault_q;

  // write decode
  wire aw_take = S_AXI_AWVALID && awready_q;
  wire w_take = S_AXI_WVALID && wready_q;
  wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
  wire [7:0] wr_ofs = awaddr_q & OFS_WORD_MASK;
  wire wr_known = ofs_known(wr_ofs);
  wire wr_ctrl = wr_fire && (wr_ofs == OFS_CTRL);
  wire wr_rnum = wr_fire && (wr_ofs == OFS_RNUM);
  wire wr_rattr = wr_fire && (wr_ofs == OFS_RATTR);
  wire wr_fstat = wr_fire && (wr_ofs == OFS_FSTAT);
  wire wr_faddr = wr_fire && (wr_ofs == OFS_FADDR);
  wire b_done = bvalid_q && S_AXI_BREADY;

  // read decode
  wire ar_take = S_AXI_ARVALID && arready_q;
  wire [7:0] rd_ofs = S_AXI_ARADDR & OFS_WORD_MASK;
  wire rd_known = ofs_known(rd_ofs);
  wire [2:0] cur_region = rnum_q[2:0];
  wire [31:0] rd_word = (rd_ofs == OFS_CTRL) ? ctrl_q :
                        (rd_ofs == OFS_RNUM) ? rnum_q :
                        (rd_ofs == OFS_RATTR) ? rattr_q[cur_region] :
                        (rd_ofs == OFS_FSTAT) ? fstat_q :
                        (rd_ofs == OFS_FADDR) ? faddr_q : 32'h0000_0000;
  wire r_done = rvalid_q && S_AXI_RREADY;

  // access path: one set of regions for fetch and data alike
  logic [NUM_REGIONS-1:0] region_en;
  always_comb
  begin
    for (int i = 0; i < NUM_REGIONS; i++)
      region_en[i] = rattr_q[i][ATTR_EN_BIT];
  end

  wire mpu_en = ctrl_q[CTRL_EN_BIT];
  wire bg_en = ctrl_q[CTRL_BG_BIT];
  wire [NUM_REGIONS-1:0] live_hit = ACC_HIT & region_en;
  wire any_hit = |live_hit;
  wire [2:0] hit_idx = top_index(live_hit);
  wire rapc_attr_t hit_attr = attr_of(rattr_q[hit_idx]);
  wire rapc_dec_t hit_dec;
  wire hit_fault;

  rapc_attr_dec u_dec (
    .attr(hit_attr),
    .dec(hit_dec)
  );

  rapc_perm_chk u_chk (
    .attr(hit_attr),
    .priv(ACC_REQ.priv),
    .write(ACC_REQ.write),
    .fetch(ACC_REQ.fetch),
    .fault(hit_fault)
  );

  // background covers misses for privileged code only, and only when enabled
  wire bg_fault = !bg_en || !ACC_REQ.priv;
  wire use_bg = !mpu_en || !any_hit;
  wire acc_fault = mpu_en && (any_hit ? hit_fault : bg_fault);
  // attributes ride along for the system; they never gate the access
  wire rapc_dec_t acc_dec = use_bg ? BG_DEC : hit_dec;
  wire fault_ev = ACC_VALID && acc_fault;
  wire ifault_ev = fault_ev && ACC_REQ.fetch;
  wire dfault_ev = fault_ev && !ACC_REQ.fetch;

  // register next values; a hardware set beats a same-cycle software clear
  always_comb
  begin
    ctrl_d = wr_ctrl ? merge_strb(ctrl_q, wdata_q, wstrb_q, CTRL_WMASK) : ctrl_q;
    rnum_d = wr_rnum ? merge_strb(rnum_q, wdata_q, wstrb_q, RNUM_WMASK) : rnum_q;
    fstat_d = fstat_q;
    if (wr_fstat)
      fstat_d = fstat_q & ~merge_strb(32'h0000_0000, wdata_q, wstrb_q, 32'hffff_ffff);
    if (ifault_ev)
      fstat_d[FST_IACC_BIT] = 1'b1;
    if (dfault_ev)
    begin
      fstat_d[FST_DACC_BIT] = 1'b1;
      fstat_d[FST_ADDRV_BIT] = 1'b1;
    end
    faddr_d = wr_faddr ? merge_strb(faddr_q, wdata_q, wstrb_q, 32'hffff_ffff) : faddr_q;
    if (dfault_ev)
      faddr_d = ACC_REQ.addr;
  end

  // write channel
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
        awready_q <= 1'b0;
      end
      if (w_take)
      begin
        w_full_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
        wready_q <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_done)
      begin
        bvalid_q <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (r_done)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // control and status registers
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ctrl_q <= CTRL_RESET;
      rnum_q <= RNUM_RESET;
      fstat_q <= FST_RESET;
      faddr_q <= FADDR_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      rnum_q <= rnum_d;
      fstat_q <= fstat_d;
      faddr_q <= faddr_d;
    end
  end

  // region attribute words; byte writes allowed so one field can change alone
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < NUM_REGIONS; i++)
        rattr_q[i] <= ATTR_RESET;
    end
    else if (wr_rattr)
    begin
      rattr_q[cur_region] <= merge_strb(rattr_q[cur_region], wdata_q, wstrb_q, ATTR_WMASK);
    end
  end

  // one result per request, one cycle later
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rsp_valid_q <= 1'b0;
      rsp_fault_q <= 1'b0;
      rsp_bg_q <= 1'b0;
      rsp_region_q <= 3'h0;
      rsp_attr_q <= BG_DEC;
      mmfault_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= ACC_VALID;
      rsp_fault_q <= fault_ev;
      rsp_bg_q <= use_bg;
      rsp_region_q <= hit_idx;
      rsp_attr_q <= acc_dec;
      mmfault_q <= fault_ev;
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign RSP_VALID = rsp_valid_q;
  assign RSP_FAULT = rsp_fault_q;
  assign RSP_BG = rsp_bg_q;
  assign RSP_REGION = rsp_region_q;
  assign RSP_ATTR = rsp_attr_q;
  assign MMFAULT = mmfault_q;

endmodule

// ==== dv/rapc_props.sv ====
// concurrent checks on the ports of the region attribute and permission checker
module rapc_props
  import rapc_pkg::*;
(
  input logic CLK,
  input logic RESETN,
  input logic S_AXI_AWVALID,
  input logic S_AXI_AWREADY,
  input logic S_AXI_WVALID,
  input logic S_AXI_WREADY,
  input logic S_AXI_BVALID,
  input logic S_AXI_ARVALID,
  input logic S_AXI_ARREADY,
  input logic S_AXI_RVALID,
  input logic ACC_VALID,
  input logic [rapc_pkg::NUM_REGIONS-1:0] ACC_HIT,
  input logic RSP_VALID,
  input logic RSP_FAULT,
  input logic RSP_BG,
  input logic [2:0] RSP_REGION,
  input rapc_pkg::rapc_dec_t RSP_ATTR,
  input logic MMFAULT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_bg_answer;
    RSP_VALID && RSP_BG && RSP_ATTR == BG_DEC;
  endsequence
  a_rsp_follows_req: assert property (ACC_VALID |=> RSP_VALID)
    else $error("no response one cycle after a request");
  a_rsp_stays_quiet: assert property (!ACC_VALID |=> !RSP_VALID && !MMFAULT)
    else $error("response without a request");
  a_fault_raises_mm: assert property (MMFAULT == (RSP_VALID && RSP_FAULT))
    else $error("exception request does not match the fault");
  a_nohit_uses_bg: assert property (ACC_VALID && ACC_HIT == '0 |=> s_bg_answer)
    else $error("access without a hit did not use the default map");
  a_bg_default_attr: assert property (RSP_VALID && RSP_BG |-> RSP_ATTR == BG_DEC)
    else $error("default map answer carries wrong attributes");
  a_region_was_hit: assert property (RSP_VALID && !RSP_BG |-> ((8'h01 << RSP_REGION) & $past(ACC_HIT)) != '0)
    else $error("reported region was not hit");
  a_rsvd_strong_order: assert property (RSP_VALID && RSP_ATTR.reserved |-> RSP_ATTR.mtype == MT_STRONG)
    else $error("reserved encoding not strongly ordered");
  a_wr_gets_answer: assert property (s_wr_taken |-> ##[1:2] S_AXI_BVALID)
    else $error("write response late");
  a_rd_gets_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer late");
endmodule

bind rapc_top rapc_props i_props (
  .CLK(CLK), .RESETN(RESETN), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .ACC_VALID(ACC_VALID), .ACC_HIT(ACC_HIT), .RSP_VALID(RSP_VALID), .RSP_FAULT(RSP_FAULT),
  .RSP_BG(RSP_BG), .RSP_REGION(RSP_REGION), .RSP_ATTR(RSP_ATTR), .MMFAULT(MMFAULT)
);

// ==== dv/rapc_core_model.sv ====
// processor-side requester issuing load, store and fetch checks
module rapc_core_model
  import rapc_pkg::*;
(
  input logic CLK,
  output logic acc_valid,
  output rapc_pkg::rapc_acc_req_t acc_req,
  output logic [rapc_pkg::NUM_REGIONS-1:0] acc_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    acc_valid = 1'b0;
    acc_req = '0;
    acc_hit = '0;
  end
  // one request per call; calls made right after an edge go back to back
  task automatic send(input logic [31:0] a, input logic p, input logic w, input logic f,
                      input logic [rapc_pkg::NUM_REGIONS-1:0] hit, input logic last);
    acc_valid <= 1'b1;
    acc_req <= '{a, p, w, f};
    acc_hit <= hit;
    @(posedge CLK);
    if (last)
    begin
      // idle lines carry junk so a design that ignores valid is caught
      acc_valid <= 1'b0;
      acc_req <= ~acc_req;
      acc_hit <= ~acc_hit;
    end
  endtask
endmodule

// ==== dv/rapc_top_test.sv ====
// self-checking bench for the region attribute and permission checker
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module rapc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rapc_pkg::*;
  logic clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, acc_valid, rsp_valid, rsp_fault, rsp_bg, mmfault;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] rsp_region;
  logic [NUM_REGIONS-1:0] acc_hit;
  rapc_acc_req_t acc_req;
  rapc_dec_t rsp_attr;
  int bad_count = 0;
  int tests_run = 0;
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  rapc_core_model i_core (.CLK(clk), .acc_valid(acc_valid), .acc_req(acc_req), .acc_hit(acc_hit));
  rapc_top i_dut (
    .CLK(clk), .RESETN(resetn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(aw_rdy),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(w_rdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(b_vld), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(r_vld), .S_AXI_RREADY(rready), .ACC_VALID(acc_valid), .ACC_REQ(acc_req),
    .ACC_HIT(acc_hit), .RSP_VALID(rsp_valid), .RSP_FAULT(rsp_fault), .RSP_BG(rsp_bg),
    .RSP_REGION(rsp_region), .RSP_ATTR(rsp_attr), .MMFAULT(mmfault)
  );
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo;
    bad_count++;
    $display("[FAIL] %0t bus wait ran out", $time);
    print_verdict();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge clk);
      if (aw_rdy)
        awvalid <= 1'b0;
      if (w_rdy)
        wvalid <= 1'b0;
      if (b_vld)
        break;
    end
    if (n == 64)
      tmo();
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge clk);
      if (ar_rdy)
        arvalid <= 1'b0;
      if (r_vld)
        break;
    end
    if (n == 64)
      tmo();
    rready <= 1'b0;
    `CHK(rdata, e)
    `CHK(rresp, er)
  endtask
  task automatic set_region(input logic [2:0] n, input logic [31:0] w);
    axi_wr(OFS_RNUM, {29'h0, n}, RESP_OKAY);
    axi_wr(OFS_RATTR, w, RESP_OKAY);
  endtask
  function automatic logic [31:0] mk(input logic xn, input logic [2:0] ap, input logic [2:0] type_extension_field,
                                     input logic [2:0] scb);
    return (32'(xn) << ATTR_XN_BIT) | (32'(ap) << ATTR_AP_LSB) | (32'(type_extension_field) << ATTR_TEX_LSB)
      | (32'(scb) << ATTR_B_BIT) | 32'h1;
  endfunction
  // pwf is {privileged, write, fetch}; the response is looked at in its single valid cycle
  task automatic acc_judge(input logic f, input logic bg, input logic [2:0] r);
    #1;
    `CHK(rsp_valid, 1'b1)
    `CHK(rsp_fault, f)
    `CHK(mmfault, f)
    `CHK(rsp_bg, bg)
    if (!bg)
      `CHK(rsp_region, r)
  endtask
  // a request followed by another is judged in the background so the next one still leaves on the edge
  task automatic acc(input logic [31:0] a, input logic [2:0] pwf, input logic [7:0] hit, input logic last,
                     input logic f, input logic bg, input logic [2:0] r);
    i_core.send(a, pwf[2], pwf[1], pwf[0], hit, last);
    if (last)
      acc_judge(f, bg, r);
    else
      fork
        acc_judge(f, bg, r);
      join_none
  endtask
  function automatic logic ap_exp(input int a, input logic p, input logic w);
    case (a)
      1: return !p;
      2: return !p && w;
      3: return 1'b0;
      5: return !p || w;
      6, 7: return w;
      default: return 1'b1;
    endcase
  endfunction
  task automatic t_reset;
    for (int i = 0; i < 5; i++)
      rd_chk(8'(4 * i), 32'h0, RESP_OKAY);
    rd_chk(8'h14, 32'h0, RESP_SLVERR);
    axi_wr(8'h14, 32'hffff_ffff, RESP_SLVERR);
    axi_wr(OFS_CTRL, 32'hffff_ffff, RESP_OKAY);
    rd_chk(OFS_CTRL, CTRL_WMASK, RESP_OKAY);
    axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
    // checker off: even an unprivileged write passes on the default map
    acc(32'h2000_0000, 3'b010, 8'hff, 1'b1, 1'b0, 1'b1, 3'h0);
    `CHK(rsp_attr, BG_DEC)
    $display("t_reset done");
  endtask
  task automatic t_ap;
    axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
    for (int a = 0; a < 8; a++)
    begin
      set_region(3'h2, mk(1'b0, 3'(a), 3'h0, 3'b010));
      for (int k = 0; k < 4; k++)
        acc(32'h0000_4000, {k[1], k[0], 1'b0}, 8'h44, k == 3, ap_exp(a, k[1], k[0]), 1'b0, 3'h2);
    end
    $display("t_ap done");
  endtask
  task automatic t_xn;
    // the permission sweep left data faults behind; see them, then clear them
    rd_chk(OFS_FSTAT, (32'h1 << FST_DACC_BIT) | (32'h1 << FST_ADDRV_BIT), RESP_OKAY);
    rd_chk(OFS_FADDR, 32'h0000_4000, RESP_OKAY);
    axi_wr(OFS_FSTAT, 32'hffff_ffff, RESP_OKAY);
    set_region(3'h4, mk(1'b1, AP_FULL, 3'h0, 3'b010));
    acc(32'h0000_1000, 3'b101, 8'h10, 1'b0, 1'b1, 1'b0, 3'h4);
    acc(32'h0000_1004, 3'b000, 8'h10, 1'b1, 1'b0, 1'b0, 3'h4);
    rd_chk(OFS_FSTAT, 32'h1 << FST_IACC_BIT, RESP_OKAY);
    axi_wr(OFS_FSTAT, 32'hff, RESP_OKAY);
    rd_chk(OFS_FSTAT, 32'h0, RESP_OKAY);
    set_region(3'h4, mk(1'b0, AP_NONE, 3'h0, 3'b010));
    acc(32'h1234_5678, 3'b110, 8'h10, 1'b1, 1'b1, 1'b0, 3'h4);
    rd_chk(OFS_FSTAT, (32'h1 << FST_DACC_BIT) | (32'h1 << FST_ADDRV_BIT), RESP_OKAY);
    rd_chk(OFS_FADDR, 32'h1234_5678, RESP_OKAY);
    $display("t_xn done");
  endtask
  task automatic t_decode;
    logic [5:0] enc[15] = '{6'h00, 6'h05, 6'h02, 6'h06, 6'h07, 6'h0c, 6'h0b, 6'h09, 6'h14, 6'h12, 6'h18,
                            6'h2e, 6'h33, 6'h20, 6'h0a};
    logic [7:0] dec[15] = '{8'h20, 8'h60, 8'h94, 8'hb4, 8'hb4, 8'ha0, 8'h8a, 8'h21, 8'h40, 8'h21, 8'h21,
                            8'hb2, 8'h9c, 8'h80, 8'h21};
    logic [7:0] m;
    for (int i = 0; i < 15; i++)
    begin
      set_region(3'h1, mk(1'b0, AP_FULL, enc[i][5:3], enc[i][2:0]));
      // attributes never change the outcome of an unprivileged write to a full-access region
      acc(32'h0000_8000, 3'b010, 8'h02, 1'b1, 1'b0, 1'b0, 3'h1);
      m = (dec[i][7:6] == 2'h2) ? 8'hff : 8'he1;
      `CHK(8'(rsp_attr) & m, dec[i] & m)
    end
    $display("t_decode done");
  endtask
  task automatic t_overlap;
    set_region(3'h3, mk(1'b0, AP_FULL, 3'h0, 3'b010));
    set_region(3'h5, mk(1'b0, AP_NONE, 3'h0, 3'b010));
    acc(32'h0000_0100, 3'b100, 8'h28, 1'b0, 1'b1, 1'b0, 3'h5);
    acc(32'h0000_0104, 3'b100, 8'h88, 1'b0, 1'b0, 1'b0, 3'h3);
    acc(32'h0000_0108, 3'b100, 8'h80, 1'b1, 1'b1, 1'b1, 3'h0);
    axi_wr(OFS_CTRL, 32'h3, RESP_OKAY);
    acc(32'h0000_010c, 3'b100, 8'h00, 1'b0, 1'b0, 1'b1, 3'h0);
    acc(32'h0000_0110, 3'b000, 8'h00, 1'b1, 1'b1, 1'b1, 3'h0);
    $display("t_overlap done");
  endtask
  initial
  begin
    resetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_ap();
    t_xn();
    t_decode();
    t_overlap();
    print_verdict();
  end
endmodule
